// ### sdram_bank_state.sv
// Per-bank open-row tracking and precharge-period timer
`timescale 1ns/1ps
module sdram_bank_state
	import sdram_pkg::*;
#(
	parameter int ROW_BITS = ROW_W,
	parameter int PRE_CYC  = PRECHARGE_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_i,
	// Requests
	input  wire logic                activate_i,
	input  wire logic                precharge_i,
	input  wire logic [ROW_BITS-1:0] row_i,
	// State
	output logic                     active_o,
	output logic                     ready_o,
	output logic [ROW_BITS-1:0]      open_row_o
);

	localparam int CW = $clog2(PRE_CYC + 1);

	logic                active_r, active_nxt;
	logic [ROW_BITS-1:0] row_r, row_nxt;
	logic [CW-1:0]       cnt_r, cnt_nxt;

	always_comb begin
		active_nxt = active_r;
		row_nxt    = row_r;
		cnt_nxt    = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		if (precharge_i && active_r) begin
			active_nxt = 1'b0;
			cnt_nxt    = CW'(PRE_CYC - 1);
		end else if (activate_i) begin
			active_nxt = 1'b1;
			row_nxt    = row_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			active_r <= 1'b0;
			row_r    <= '0;
			cnt_r    <= '0;
		end else begin
			active_r <= active_nxt;
			row_r    <= row_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	assign active_o   = active_r;
	assign ready_o    = !active_r && (cnt_r == '0);
	assign open_row_o = row_r;

endmodule // sdram_bank_state

// ### sdram_command_interface.sv
// SDRAM device: command decode, bank control, burst engine, array and data pins
`timescale 1ns/1ps
// Notes on behaviour
// - Chip select high: no new command taken, running operations carry on.
// - Selected no-operation does nothing and leaves running operations alone.
// - Decode with clock enable high; refresh code with it low enters self refresh.
// - ACTIVE opens the addressed row in the selected bank until precharged.
// - READ/WRITE take bank and start column; auto-precharge bit is per command.
// - Read mask high hides read data two clocks later.
// - Write mask sampled with the data blocks that byte from the array.
// - PRECHARGE closes selected bank, or all banks when auto-precharge bit high.
// - Precharged bank idle and usable only after the precharge period.
// - Auto precharge closes bank at burst end; none for full-page bursts.
// - BURST TERMINATE cuts the latest burst and keeps the row open.
// - Auto refresh rows come from the internal counter, not address pins.
// - In self refresh only clock enable matters; it must stay low.
// - Self refresh runs its own timed refresh cycles.
// - Read data appears the programmed latency, two or three, after READ.
// - Write-burst mode bit set makes writes single-location, reads keep length.
module sdram_command_interface
	import sdram_pkg::*;
#(
	parameter int DATA_W   = 16,
	parameter int COL_W    = 9,
	parameter int ROW_BITS = ROW_W,
	parameter int REF_TICK = REFRESH_INTERVAL_CYC,
	parameter int EXIT_CYC = SELF_REFRESH_EXIT_DELAY_CYC
) (
	// Clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// Command pins
	input  wire logic                  cke_i,
	input  wire logic                  cs_n_i,
	input  wire logic                  ras_n_i,
	input  wire logic                  cas_n_i,
	input  wire logic                  we_n_i,
	input  wire logic                  bank_select_bit0_i,
	input  wire logic                  bank_select_bit1_i,
	input  wire logic [ADDR_W-1:0]     addr_i,
	// Data pins
	input  wire logic [DATA_W/8-1:0]   dqm_i,
	input  wire logic [DATA_W-1:0]     dq_i,
	output logic      [DATA_W-1:0]     dq_o,
	output logic      [DATA_W/8-1:0]   dq_oe_o,
	// Status
	output logic                       self_refresh_o,
	output logic      [BANKS-1:0]      bank_active_o,
	output logic      [ROW_BITS-1:0]   refresh_row_o,
	output logic                       refresh_pulse_o,
	output logic                       illegal_cmd_o,
	output logic      [MODE_W-1:0]     mode_o
);

	localparam int LANES = DATA_W / 8;
	localparam int IDX_W = BANK_W + ROW_BITS + COL_W;
	localparam int XW    = $clog2(EXIT_CYC + 1);
	localparam logic [COL_MAX_W-1:0] FULL_MASK = COL_MAX_W'((1 << COL_W) - 1);

	// Array sized by parameters; shrink COL_W/ROW_BITS for fast simulation
	logic [DATA_W-1:0] mem [0:(2**IDX_W)-1];

	logic [BANK_W-1:0]   bank_sel;
	logic                auto_precharge_select;
	cmd_e                cmd;
	logic [BANKS-1:0]    bank_active;
	logic [BANKS-1:0]    bank_ready;
	logic [BANKS-1:0]    act_req;
	logic [BANKS-1:0]    pre_req;
	logic [ROW_BITS-1:0] open_row [BANKS];
	logic                all_idle;

	dev_state_e        state_r, state_nxt;
	logic [XW-1:0]     exit_r, exit_nxt;
	logic [MODE_W-1:0] mode_r, mode_nxt;
	burst_s            burst_r, b_nxt;
	logic [1:0]        ap_cnt_r, ap_cnt_nxt;
	logic [BANK_W-1:0] ap_bank_r, ap_bank_nxt;
	logic              illegal_r, illegal_nxt;

	logic                 beat;
	logic                 beat_rd;
	logic                 new_wr;
	logic                 ref_req;
	logic [BANK_W-1:0]    beat_bank;
	logic [ROW_BITS-1:0]  beat_row;
	logic [COL_W-1:0]     beat_col;
	logic [IDX_W-1:0]     beat_idx;
	logic [DATA_W-1:0]    rd_word;
	logic [3:0]           len;
	logic                 full;
	logic [COL_MAX_W-1:0] col_inc;

	logic [DATA_W-1:0] p1_r, p1_nxt, p2_r, p2_nxt, dq_r, dq_nxt;
	logic              p1v_r, p1v_nxt, p2v_r, p2v_nxt;
	logic [LANES-1:0]  dqm_d1_r, oe_r, oe_nxt;

	assign bank_sel              = {bank_select_bit1_i, bank_select_bit0_i};
	assign auto_precharge_select = addr_i[AP_BIT];
	assign all_idle              = &bank_ready;

	// Command decode; clock enable low leaves only self-refresh entry
	always_comb begin
		cmd = CMD_INHIBIT;
		if (!cs_n_i) begin
			case ({ras_n_i, cas_n_i, we_n_i})
				3'h7:    cmd = CMD_NOP;
				3'h3:    cmd = CMD_ACTIVE;
				3'h5:    cmd = CMD_READ;
				3'h4:    cmd = CMD_WRITE;
				3'h6:    cmd = CMD_TERMINATE;
				3'h2:    cmd = CMD_PRECHARGE;
				3'h1:    cmd = cke_i ? CMD_REFRESH : CMD_SELF_REFRESH;
				3'h0:    cmd = CMD_MODE_LOAD;
				default: cmd = CMD_NOP;
			endcase
			if (!cke_i && cmd != CMD_SELF_REFRESH)
				cmd = CMD_NOP;
		end
	end

	// Burst length from mode; write-burst mode bit forces single writes
	always_comb begin
		full = 1'b0;
		case (mode_r[MODE_BL_LSB +: 3])
			BL_1:    len = 4'h1;
			BL_2:    len = 4'h2;
			BL_4:    len = 4'h4;
			BL_8:    len = 4'h8;
			BL_FULL: begin
				len  = 4'h1;
				full = 1'b1;
			end
			default: len = 4'h1;
		endcase
		if (cmd == CMD_WRITE && mode_r[MODE_WB_BIT]) begin
			len  = 4'h1;
			full = 1'b0;
		end
	end

	always_comb begin
		state_nxt   = state_r;
		exit_nxt    = exit_r;
		mode_nxt    = mode_r;
		b_nxt       = burst_r;
		ap_cnt_nxt  = (ap_cnt_r != 2'h0) ? ap_cnt_r - 2'h1 : ap_cnt_r;
		ap_bank_nxt = ap_bank_r;
		act_req     = '0;
		pre_req     = '0;
		ref_req     = 1'b0;
		illegal_nxt = 1'b0;
		new_wr      = 1'b0;
		beat        = 1'b0;
		beat_rd     = burst_r.is_read;
		beat_bank   = burst_r.bank;
		beat_row    = burst_r.row[ROW_BITS-1:0];
		beat_col    = burst_r.col[COL_W-1:0];
		col_inc     = burst_r.col + 12'h001;
		if (ap_cnt_r == 2'h1)
			pre_req[ap_bank_r] = 1'b1;
		// Running burst advances each cycle unless a READ, WRITE, BURST TERMINATE or matching PRECHARGE below replaces or stops it
		if (burst_r.active) begin
			beat         = 1'b1;
			b_nxt.col    = (burst_r.col & ~burst_r.mask) | (col_inc & burst_r.mask);
			b_nxt.remain = burst_r.remain - 4'h1;
			if (!burst_r.full && burst_r.remain == 4'h1) begin
				b_nxt.active = 1'b0;
				if (burst_r.ap) begin
					ap_cnt_nxt  = burst_r.is_read ? READ_AP_DELAY : WRITE_RECOVERY_CYC;
					ap_bank_nxt = burst_r.bank;
				end
			end
		end
		case (state_r)
			ST_NORMAL: begin
				case (cmd)
					CMD_ACTIVE: begin
						if (bank_ready[bank_sel])
							act_req[bank_sel] = 1'b1;
						else
							illegal_nxt = 1'b1;
					end
					CMD_READ, CMD_WRITE: begin
						if (bank_active[bank_sel]) begin
							// Truncated burst still owes its auto precharge
							if (burst_r.active && burst_r.ap) begin
								ap_cnt_nxt  = burst_r.is_read ? READ_AP_DELAY
									: WRITE_RECOVERY_CYC;
								ap_bank_nxt = burst_r.bank;
							end
							beat           = 1'b1;
							beat_rd        = (cmd == CMD_READ);
							new_wr         = (cmd == CMD_WRITE);
							beat_bank      = bank_sel;
							beat_row       = open_row[bank_sel];
							beat_col       = addr_i[COL_W-1:0];
							b_nxt.is_read  = beat_rd;
							b_nxt.full     = full;
							b_nxt.ap       = auto_precharge_select && !full;
							b_nxt.bank     = bank_sel;
							b_nxt.row      = ROW_W'(open_row[bank_sel]);
							b_nxt.mask     = full ? FULL_MASK : {8'h00, len - 4'h1};
							col_inc        = COL_MAX_W'(addr_i[COL_W-1:0]) + 12'h001;
							b_nxt.col      = (COL_MAX_W'(addr_i[COL_W-1:0]) & ~b_nxt.mask)
								| (col_inc & b_nxt.mask);
							b_nxt.remain   = len - 4'h1;
							b_nxt.active   = full || (len != 4'h1);
							if (!b_nxt.active && b_nxt.ap) begin
								ap_cnt_nxt  = beat_rd ? READ_AP_DELAY : WRITE_RECOVERY_CYC;
								ap_bank_nxt = bank_sel;
							end
						end else begin
							illegal_nxt = 1'b1;
						end
					end
					CMD_TERMINATE: begin
						beat         = 1'b0;
						b_nxt.active = 1'b0;
					end
					CMD_PRECHARGE: begin
						if (auto_precharge_select)
							pre_req = '1;
						else
							pre_req[bank_sel] = 1'b1;
						if (burst_r.active && (auto_precharge_select
							|| burst_r.bank == bank_sel)) begin
							beat         = 1'b0;
							b_nxt.active = 1'b0;
						end
					end
					CMD_REFRESH: begin
						if (all_idle)
							ref_req = 1'b1;
						else
							illegal_nxt = 1'b1;
					end
					CMD_SELF_REFRESH: begin
						if (all_idle)
							state_nxt = ST_SELF_REFRESH;
						else
							illegal_nxt = 1'b1;
					end
					CMD_MODE_LOAD: begin
						if (all_idle)
							mode_nxt = addr_i[MODE_W-1:0];
						else
							illegal_nxt = 1'b1;
					end
					default: ;
				endcase
			end
			ST_SELF_REFRESH: begin
				if (cke_i) begin
					state_nxt = ST_EXIT;
					exit_nxt  = XW'(EXIT_CYC - 1);
				end
			end
			ST_EXIT: begin
				if (exit_r == '0)
					state_nxt = ST_NORMAL;
				else
					exit_nxt = exit_r - 1'b1;
				if (cmd != CMD_NOP && cmd != CMD_INHIBIT)
					illegal_nxt = 1'b1;
			end
			default: state_nxt = ST_NORMAL;
		endcase
	end

	assign beat_idx = {beat_bank, beat_row, beat_col};
	assign rd_word  = mem[beat_idx];

	always_ff @(posedge core_clk_i) begin
		if (beat && !beat_rd) begin
			for (int l = 0; l < LANES; l++) begin
				if (!dqm_i[l])
					mem[beat_idx][l*8 +: 8] <= dq_i[l*8 +: 8];
			end
		end
	end

	// Read pipeline; a WRITE drops pending read data to free the bus
	always_comb begin
		p1_nxt  = rd_word;
		p1v_nxt = beat && beat_rd;
		p2_nxt  = p1_r;
		p2v_nxt = p1v_r;
		if (mode_r[MODE_CL_LSB +: 3] == CL_3) begin
			dq_nxt = p2_r;
			oe_nxt = p2v_r ? ~dqm_d1_r : '0;
		end else begin
			dq_nxt = p1_r;
			oe_nxt = p1v_r ? ~dqm_d1_r : '0;
		end
		if (new_wr) begin
			p1v_nxt = 1'b0;
			p2v_nxt = 1'b0;
			oe_nxt  = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r   <= ST_NORMAL;
			exit_r    <= '0;
			mode_r    <= MODE_RESET;
			burst_r   <= '0;
			ap_cnt_r  <= 2'h0;
			ap_bank_r <= '0;
			illegal_r <= 1'b0;
			p1_r      <= '0;
			p2_r      <= '0;
			p1v_r     <= 1'b0;
			p2v_r     <= 1'b0;
			dq_r      <= '0;
			oe_r      <= '0;
			dqm_d1_r  <= '0;
		end else begin
			state_r   <= state_nxt;
			exit_r    <= exit_nxt;
			mode_r    <= mode_nxt;
			burst_r   <= b_nxt;
			ap_cnt_r  <= ap_cnt_nxt;
			ap_bank_r <= ap_bank_nxt;
			illegal_r <= illegal_nxt;
			p1_r      <= p1_nxt;
			p2_r      <= p2_nxt;
			p1v_r     <= p1v_nxt;
			p2v_r     <= p2v_nxt;
			dq_r      <= dq_nxt;
			oe_r      <= oe_nxt;
			dqm_d1_r  <= dqm_i;
		end
	end

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		sdram_bank_state #(
			.ROW_BITS (ROW_BITS),
			.PRE_CYC  (PRECHARGE_PERIOD_CYC)
		) u_bank (
			.core_clk_i  (core_clk_i),
			.rst_i       (rst_i),
			.activate_i  (act_req[b]),
			.precharge_i (pre_req[b]),
			.row_i       (addr_i[ROW_BITS-1:0]),
			.active_o    (bank_active[b]),
			.ready_o     (bank_ready[b]),
			.open_row_o  (open_row[b])
		);
	end

	sdram_refresh_ctr #(
		.ROW_BITS (ROW_BITS),
		.TICK_CYC (REF_TICK)
	) u_refresh (
		.core_clk_i      (core_clk_i),
		.rst_i           (rst_i),
		.auto_refresh_i  (ref_req),
		.self_refresh_i  (state_r == ST_SELF_REFRESH),
		.refresh_row_o   (refresh_row_o),
		.refresh_pulse_o (refresh_pulse_o)
	);

	assign dq_o           = dq_r;
	assign dq_oe_o        = oe_r;
	assign self_refresh_o = (state_r == ST_SELF_REFRESH);
	assign bank_active_o  = bank_active;
	assign illegal_cmd_o  = illegal_r;
	assign mode_o         = mode_r;

endmodule // sdram_command_interface

// ### sdram_command_interface_chk.sv
// Assertions on the device command pins, bank state and data outputs
`timescale 1ns/1ps
module sdram_command_interface_chk
	import sdram_pkg::*;
#(
	parameter int DATA_W   = 16,
	parameter int ROW_BITS = ROW_W,
	parameter int REF_TICK = REFRESH_INTERVAL_CYC
) (
	// Clock and reset
	input wire logic                core_clk_i,
	input wire logic                rst_i,
	// Command pins
	input wire logic                cke_i,
	input wire logic                cs_n_i,
	input wire logic                ras_n_i,
	input wire logic                cas_n_i,
	input wire logic                we_n_i,
	input wire logic                bank_select_bit0_i,
	input wire logic                bank_select_bit1_i,
	input wire logic [ADDR_W-1:0]   addr_i,
	input wire logic [DATA_W/8-1:0] dqm_i,
	// Device outputs
	input wire logic [DATA_W/8-1:0] dq_oe_o,
	input wire logic                self_refresh_o,
	input wire logic [BANKS-1:0]    bank_active_o,
	input wire logic [ROW_BITS-1:0] refresh_row_o,
	input wire logic                refresh_pulse_o,
	input wire logic                illegal_cmd_o,
	input wire logic [MODE_W-1:0]   mode_o
);
	logic [3:0]  code;
	logic [1:0]  bsel;
	logic        sel;
	logic        act;
	logic        sr_cmd;
	logic        rd_ok;
	int unsigned quiet_r;
	int unsigned quiet_nxt;

	assign code   = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
	assign bsel   = {bank_select_bit1_i, bank_select_bit0_i};
	assign sel    = cke_i && !self_refresh_o;
	assign act    = cke_i && code == 4'h3;
	assign sr_cmd = !cke_i && code == 4'h1;
	assign rd_ok  = sel && code == 4'h5 && bank_active_o[bsel]
		&& mode_o[MODE_CL_LSB +: 3] != CL_3;

	// Cycles spent in self refresh since the last timed refresh
	always_comb begin
		quiet_nxt = (self_refresh_o && !refresh_pulse_o) ? quiet_r + 1 : 0;
	end
	always_ff @(posedge core_clk_i) begin
		quiet_r <= rst_i ? 0 : quiet_nxt;
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	AST_INHIBIT: assert property (sel && cs_n_i |=>
		(bank_active_o & ~$past(bank_active_o)) == '0 && $stable(mode_o))
		else $error("deselected cycle changed bank or mode state");
	AST_NOP: assert property (sel && code == 4'h7 |=>
		(bank_active_o & ~$past(bank_active_o)) == '0 && $stable(mode_o) && !illegal_cmd_o)
		else $error("no-operation changed device state");
	AST_ACT_CAUSE: assert property ((bank_active_o & ~$past(bank_active_o)) != '0 |-> $past(act))
		else $error("bank opened without an activate");
	AST_PRE_ALL: assert property (cke_i && code == 4'h2 && addr_i[AP_BIT] |=> bank_active_o == '0)
		else $error("precharge all left a bank open");
	AST_PRE_ONE: assert property (cke_i && code == 4'h2 |=> !bank_active_o[$past(bsel)])
		else $error("precharged bank still open");
	AST_READ_MASK: assert property (rd_ok ##1 !(cke_i && code == 4'h4) |->
		##1 dq_oe_o == ~$past(dqm_i, 2))
		else $error("read drive enable does not follow mask two cycles back");
	AST_ROW_STEP: assert property (refresh_row_o != $past(refresh_row_o) |->
		refresh_pulse_o && refresh_row_o == $past(refresh_row_o) + 1'b1)
		else $error("refresh row moved without a refresh");
	AST_SR_ENTER: assert property ($rose(self_refresh_o) |-> $past(sr_cmd))
		else $error("self refresh entered without its command");
	AST_SR_HOLD: assert property (self_refresh_o && !cke_i |=>
		self_refresh_o && $stable(bank_active_o) && $stable(mode_o) && !illegal_cmd_o)
		else $error("input acted on during self refresh");
	AST_SR_TICK: assert property (quiet_r <= REF_TICK + 1)
		else $error("self refresh missed its timed refresh");
endmodule // sdram_command_interface_chk

bind sdram_command_interface sdram_command_interface_chk #(
	.DATA_W(DATA_W), .ROW_BITS(ROW_BITS), .REF_TICK(REF_TICK)
) sdram_command_interface_chk_i (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
	.ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
	.bank_select_bit0_i(bank_select_bit0_i), .bank_select_bit1_i(bank_select_bit1_i),
	.addr_i(addr_i), .dqm_i(dqm_i), .dq_oe_o(dq_oe_o), .self_refresh_o(self_refresh_o),
	.bank_active_o(bank_active_o), .refresh_row_o(refresh_row_o),
	.refresh_pulse_o(refresh_pulse_o), .illegal_cmd_o(illegal_cmd_o), .mode_o(mode_o)
);

// ### sdram_ctl_model.sv
// Memory controller model driving the device command and data pins
`timescale 1ns/1ps
module sdram_ctl_model
	import sdram_pkg::*;
(
	// Clock
	input  wire logic          core_clk_i,
	// Command and data pins
	output logic               cke_o,
	output logic               cs_n_o,
	output logic               ras_n_o,
	output logic               cas_n_o,
	output logic               we_n_o,
	output logic [1:0]         ba_o,
	output logic [ADDR_W-1:0]  addr_o,
	output logic [1:0]         dqm_o,
	output logic [15:0]        dq_o
);
	logic asleep = 1'b0;

	initial begin
		cke_o = 1'b1;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = 2'h0;
		addr_o = '0;
		dqm_o = 2'h0;
		dq_o = 16'h0000;
	end

	// Released data lines toggle so a stale value never looks valid
	task automatic issue(input cmd_e c, input logic [1:0] ba, input logic [ADDR_W-1:0] a,
		input logic [1:0] m, input logic [15:0] d, input bit keep);
		logic [3:0] code;
		case (c)
			CMD_INHIBIT:   code = 4'hB;
			CMD_NOP:       code = 4'h7;
			CMD_ACTIVE:    code = 4'h3;
			CMD_READ:      code = 4'h5;
			CMD_WRITE:     code = 4'h4;
			CMD_TERMINATE: code = 4'h6;
			CMD_PRECHARGE: code = 4'h2;
			CMD_MODE_LOAD: code = 4'h0;
			default:       code = 4'h1;
		endcase
		if (c == CMD_SELF_REFRESH)
			asleep = 1'b1;
		@(posedge core_clk_i);
		cke_o <= !asleep;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= code;
		ba_o <= ba;
		addr_o <= a;
		dqm_o <= m;
		dq_o <= (c == CMD_WRITE || keep) ? d : ~dq_o;
	endtask

	task automatic idle(input int n);
		repeat (n) issue(CMD_NOP, 2'h0, '0, 2'h0, 16'h0000, 1'b0);
	endtask

	// Clock keeps running, so raising clock enable is the whole exit
	task automatic wake();
		asleep = 1'b0;
	endtask
endmodule // sdram_ctl_model

// ### sdram_pkg.sv
// Shared constants, command and state types for the SDRAM device model
package sdram_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int BANKS         = 4;
	localparam int BANK_W        = 2;
	localparam int ADDR_W        = 13;
	localparam int ROW_W         = 12;
	localparam int MODE_W        = 12;
	localparam int COL_MAX_W     = 12;
	localparam int AP_BIT        = 10;

	// Mode register fields
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WB_BIT = 9;
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_3    = 3'h3;
	localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;

	// Timing
	localparam int PRECHARGE_PERIOD_NS = 20;
	localparam int PRECHARGE_PERIOD_CYC =
		(PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELF_REFRESH_EXIT_DELAY_NS = 75;
	localparam int SELF_REFRESH_EXIT_DELAY_CYC =
		(SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_INTERVAL_NS  = 15625;
	localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam logic [1:0] WRITE_RECOVERY_CYC = 2'h2;
	localparam logic [1:0] READ_AP_DELAY      = 2'h1;

	typedef enum logic [3:0] {
		CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_TERMINATE,
		CMD_PRECHARGE, CMD_REFRESH, CMD_SELF_REFRESH, CMD_MODE_LOAD
	} cmd_e;

	typedef enum logic [1:0] {
		ST_NORMAL, ST_SELF_REFRESH, ST_EXIT
	} dev_state_e;

	typedef struct packed {
		logic                 active;
		logic                 is_read;
		logic                 ap;
		logic                 full;
		logic [BANK_W-1:0]    bank;
		logic [ROW_W-1:0]     row;
		logic [COL_MAX_W-1:0] col;
		logic [COL_MAX_W-1:0] mask;
		logic [3:0]           remain;
	} burst_s;

endpackage

// ### sdram_refresh_ctr.sv
// Refresh row counter with self-timed tick for self refresh
`timescale 1ns/1ps
module sdram_refresh_ctr
	import sdram_pkg::*;
#(
	parameter int ROW_BITS = ROW_W,
	parameter int TICK_CYC = REFRESH_INTERVAL_CYC
) (
	// Clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_i,
	// Requests
	input  wire logic                auto_refresh_i,
	input  wire logic                self_refresh_i,
	// State
	output logic [ROW_BITS-1:0]      refresh_row_o,
	output logic                     refresh_pulse_o
);

	localparam int DW = $clog2(TICK_CYC + 1);

	logic [DW-1:0]       div_r, div_nxt;
	logic [ROW_BITS-1:0] row_r, row_nxt;
	logic                pulse_r, pulse_nxt;
	logic                tick;

	always_comb begin
		tick    = self_refresh_i && (div_r == '0);
		div_nxt = div_r;
		if (!self_refresh_i || tick)
			div_nxt = DW'(TICK_CYC - 1);
		else
			div_nxt = div_r - 1'b1;
		pulse_nxt = auto_refresh_i || tick;
		row_nxt   = pulse_nxt ? row_r + 1'b1 : row_r;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			div_r   <= '0;
			row_r   <= '0;
			pulse_r <= 1'b0;
		end else begin
			div_r   <= div_nxt;
			row_r   <= row_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign refresh_row_o   = row_r;
	assign refresh_pulse_o = pulse_r;

endmodule // sdram_refresh_ctr

// ### testbench.sv
// Self-checking testbench for the SDRAM device command interface
`timescale 1ns/1ps
module testbench
	import sdram_pkg::*;
;
	localparam int TICK    = 8;
	localparam int EXITC   = 2;
	localparam int PRE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MRD_CYC = 2;
	localparam int RAS_CYC = 5;

	logic              core_clk_i = 1'b0;
	logic              rst_i      = 1'b1;
	logic              cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0]        ba, dqm, dq_oe;
	logic [ADDR_W-1:0] addr;
	logic [15:0]       dq_in, dq_out;
	logic [3:0]        bact, rrow;
	logic              sr, rpulse, illegal;
	logic [MODE_W-1:0] mode;
	int                fails       = 0;
	int                comparisons = 0;

	always #5 core_clk_i = ~core_clk_i;

	sdram_ctl_model sdram_ctl_model_i (
		.core_clk_i(core_clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
		.we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_in)
	);

	sdram_command_interface #(.COL_W(4), .ROW_BITS(4), .REF_TICK(TICK), .EXIT_CYC(EXITC))
		sdram_command_interface_i (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
		.cas_n_i(cas_n), .we_n_i(we_n), .bank_select_bit0_i(ba[0]), .bank_select_bit1_i(ba[1]),
		.addr_i(addr), .dqm_i(dqm), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe),
		.self_refresh_o(sr), .bank_active_o(bact), .refresh_row_o(rrow),
		.refresh_pulse_o(rpulse), .illegal_cmd_o(illegal), .mode_o(mode)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmd(input cmd_e c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
		sdram_ctl_model_i.issue(c, b, a, 2'h0, 16'h0000, 1'b0);
	endtask

	task automatic nop(input int n);
		sdram_ctl_model_i.idle(n);
	endtask

	task automatic step();
		nop(1);
		#1;
	endtask

	task automatic wr(input logic [1:0] b, input logic [3:0] col, input logic [63:0] d,
		input logic [7:0] m, input bit ap);
		sdram_ctl_model_i.issue(CMD_WRITE, b, {2'h0, ap, 6'h00, col}, m[1:0], d[15:0], 1'b0);
		for (int i = 1; i < 4; i++)
			sdram_ctl_model_i.issue(CMD_NOP, 2'h0, '0, m[2*i+:2], d[16*i+:16], 1'b1);
	endtask

	// Four-beat read; only lanes in cm with mask low are compared
	task automatic rd(input logic [1:0] b, input logic [3:0] col, input int lat,
		input logic [7:0] rm, input logic [63:0] ev, input logic [63:0] cm);
		logic [15:0] lm;
		logic [1:0]  em;
		int          j;
		// Mask for beat j is sampled two clocks before that beat is valid
		sdram_ctl_model_i.issue(CMD_READ, b, {9'h000, col}, (lat == 2) ? rm[1:0] : 2'h0,
			16'h0000, 1'b0);
		for (int k = 0; k <= lat + 3; k++) begin
			sdram_ctl_model_i.issue(CMD_NOP, 2'h0, '0,
				(k+3-lat < 4) ? rm[2*(k+3-lat)+:2] : 2'h0, 16'h0000, 1'b0);
			#1;
			j = k - lat + 1;
			if (j >= 0 && j < 4) begin
				lm = cm[16*j+:16] & {{8{~rm[2*j+1]}}, {8{~rm[2*j]}}};
				em = ~rm[2*j+:2];
				chk(16'(dq_oe), 16'(em));
				chk(dq_out & lm, ev[16*j+:16] & lm);
			end
		end
		chk(16'(dq_oe), 16'h0000);
	endtask

	task automatic t_reset();
		chk(16'(mode), 16'(MODE_RESET));
		chk(16'(bact), 16'h0000);
		chk(16'(rrow), 16'h0000);
		chk(16'(dq_oe), 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_activate();
		cmd(CMD_INHIBIT, 2'h2, 13'h0005);
		cmd(CMD_NOP, 2'h2, 13'h0005);
		step();
		chk(16'(bact), 16'h0000);
		cmd(CMD_ACTIVE, 2'h2, 13'h0005);
		step();
		chk(16'(bact), 16'h0004);
		cmd(CMD_ACTIVE, 2'h2, 13'h0006);
		step();
		chk(16'(illegal), 16'h0001);
		$display("test activate done");
	endtask

	task automatic t_write_read();
		cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
		step();
		chk(16'(bact), 16'h0000);
		nop(PRE_CYC);
		cmd(CMD_MODE_LOAD, 2'h0, 13'h0022);
		step();
		chk(16'(mode), 16'h0022);
		nop(MRD_CYC);
		cmd(CMD_ACTIVE, 2'h1, 13'h0003);
		nop(1);
		wr(2'h1, 4'h0, {16'h4444, 16'h3333, 16'h2222, 16'h1111}, 8'h10, 1'b0);
		rd(2'h1, 4'h0, 2, 8'h80, {16'h4444, 16'h3333, 16'h2222, 16'h1111},
			64'hFFFF_FF00_FFFF_FFFF);
		$display("test write read done");
	endtask

	task automatic t_single_write();
		cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(PRE_CYC + 1);
		cmd(CMD_MODE_LOAD, 2'h0, 13'h0232);
		nop(MRD_CYC);
		cmd(CMD_ACTIVE, 2'h1, 13'h0003);
		nop(1);
		wr(2'h1, 4'h1, {{3{16'h7777}}, 16'h5A5A}, 8'h00, 1'b0);
		rd(2'h1, 4'h0, 3, 8'h02, {16'h4444, 16'h3333, 16'h5A5A, 16'h1111},
			64'hFFFF_FF00_FFFF_FFFF);
		$display("test single write done");
	endtask

	task automatic t_autopre_term();
		cmd(CMD_ACTIVE, 2'h0, 13'h0001);
		cmd(CMD_ACTIVE, 2'h3, 13'h0001);
		nop(1);
		wr(2'h0, 4'h0, {4{16'hA5A5}}, 8'h00, 1'b1);
		nop(PRE_CYC + 2);
		#1;
		chk(16'(bact), 16'h000A);
		cmd(CMD_READ, 2'h3, 13'h0000);
		cmd(CMD_TERMINATE, 2'h0, 13'h0000);
		nop(3);
		#1;
		chk(16'(dq_oe), 16'h0000);
		chk(16'(bact), 16'h000A);
		cmd(CMD_PRECHARGE, 2'h3, 13'h0000);
		step();
		chk(16'(bact), 16'h0002);
		$display("test auto precharge done");
	endtask

	task automatic t_refresh();
		logic [3:0] r0;
		cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(PRE_CYC);
		cmd(CMD_REFRESH, 2'h3, 13'h1FFF);
		step();
		chk(16'(rrow), 16'h0001);
		chk(16'(rpulse), 16'h0001);
		cmd(CMD_SELF_REFRESH, 2'h0, 13'h0000);
		step();
		chk(16'(sr), 16'h0001);
		cmd(CMD_ACTIVE, 2'h1, 13'h0002);
		nop(2 * TICK + RAS_CYC);
		#1;
		chk(16'(bact), 16'h0000);
		chk(16'(rrow >= 4'h3), 16'h0001);
		sdram_ctl_model_i.wake();
		nop(1);
		cmd(CMD_ACTIVE, 2'h1, 13'h0002);
		step();
		chk(16'(illegal), 16'h0001);
		nop(EXITC);
		cmd(CMD_ACTIVE, 2'h1, 13'h0002);
		step();
		chk(16'(bact), 16'h0002);
		chk(16'(sr), 16'h0000);
		cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(PRE_CYC);
		r0 = rrow + 4'h1;
		cmd(CMD_REFRESH, 2'h0, 13'h0000);
		step();
		chk(16'(rrow), 16'(r0));
		$display("test refresh done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		t_reset();
		t_activate();
		t_write_read();
		t_single_write();
		t_autopre_term();
		t_refresh();
		complete_run();
	end

	// Whole run needs about 110 cycles
	initial begin
		repeat (2000) @(posedge core_clk_i);
		fails++;
		complete_run();
	end
endmodule // testbench
